// File: gated_timer_pkg.sv
// Constants, register map and field layout of the gated 16-bit timer core.
// Assumes a classic Wishbone slave with 32-bit data, registers in lane 0.
//
// Contract
// - 16-bit up count, byte writes replace live bytes
// - Run bit off stops; gate enable adds permit
// - Clock select picks osc, pin, sysclk, instr
// - System clock gives four counts per instruction
// - External rising edges counted, sync or async
// - External mode needs falling edge before counting
// - Prescaler divides by one, two, four, eight
// - Prescaler hidden, cleared by any count write
// - Crystal oscillator enable starts it, runs asleep
// - Sync disable only lets external counting run asleep
// - Async external counting continues asleep, wakes
// - Byte reads during async counting stay valid
// - Rollover FFFFh to 0000h sets overflow flag
// - Gated off counter holds its value
package gated_timer_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_COUNT_LOW   = 8'h00;
	localparam logic [7:0] OFS_COUNT_HIGH  = 8'h04;
	localparam logic [7:0] OFS_CONTROL     = 8'h08;
	localparam logic [7:0] OFS_GATE        = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'h14;

	// ==========================================================
	// Field positions in counter_control_reg
	localparam int CS_LSB      = 6;
	localparam int PS_LSB      = 4;
	localparam int OSC_EN_BIT  = 3;
	localparam int SYNC_DIS_BIT = 2;
	localparam int RUN_BIT     = 0;
	// Field position in gate_control_reg
	localparam int GATE_EN_BIT = 7;
	// Field position in status and mask
	localparam int OVF_BIT     = 0;

	// ==========================================================
	// Clock select codes
	localparam logic [1:0] CS_INSTR = 2'h0;
	localparam logic [1:0] CS_SYS   = 2'h1;
	localparam logic [1:0] CS_EXT   = 2'h2;
	localparam logic [1:0] CS_LFOSC = 2'h3;

	// ==========================================================
	// Reset values and limits
	localparam logic [7:0]  CONTROL_RST = 8'h00;
	localparam logic [7:0]  GATE_RST    = 8'h00;
	localparam logic [15:0] COUNT_RST   = 16'h0000;
	localparam logic [15:0] COUNT_MAX   = 16'hffff;
	localparam logic [1:0]  INSTR_LAST  = 2'h3;

endpackage

// File: gated_sixteen_bit_timer_core.sv
// Gated 16-bit timer core with Wishbone register access and overflow interrupt.
// Assumes all pin inputs synchronous to clk; gate logic lives outside.
`timescale 1ns/1ps

module gated_sixteen_bit_timer_core (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Count sources
	input  wire logic        ext_count_input,
	input  wire logic        low_freq_internal_osc,
	input  wire logic        crystal_in_pin,
	output logic             crystal_out_pin,
	output logic             crystal_out_oe,
	// Gate and power state
	input  wire logic        count_permit,
	input  wire logic        sleep_mode,
	// Interrupt
	output logic             irq
);

	// ==========================================================
	// Registers
	logic [15:0] count;
	logic [7:0]  control;
	logic [7:0]  gate_ctrl;
	logic        status_ovf;
	logic        mask_ovf;
	logic [2:0]  presc;
	logic [1:0]  instr_div;
	logic        ext_prev;
	logic        lf_prev;
	logic        armed;

	// ==========================================================
	// Field views
	logic [1:0] clock_select_field;
	logic [1:0] prescale_field;
	logic       crystal_osc_enable;
	logic       sync_disable_bit;
	logic       run_bit;
	logic       gate_enable_bit;

	assign clock_select_field = control[gated_timer_pkg::CS_LSB +: 2];
	assign prescale_field     = control[gated_timer_pkg::PS_LSB +: 2];
	assign crystal_osc_enable = control[gated_timer_pkg::OSC_EN_BIT];
	assign sync_disable_bit   = control[gated_timer_pkg::SYNC_DIS_BIT];
	assign run_bit            = control[gated_timer_pkg::RUN_BIT];
	assign gate_enable_bit    = gate_ctrl[gated_timer_pkg::GATE_EN_BIT];

	function automatic logic [2:0] presc_last(input logic [1:0] ps);
		presc_last = 3'((4'h1 << ps) - 4'h1);
	endfunction

	// ==========================================================
	// Bus decode
	logic req;
	logic wr;
	logic wr_low;
	logic wr_high;
	logic wr_count;

	assign req      = wb_cyc_i & wb_stb_i;
	// Writes commit at the edge where ack is high
	assign wr       = req & wb_we_i & wb_ack_o & wb_sel_i[0];
	assign wr_low   = wr & (wb_adr_i == gated_timer_pkg::OFS_COUNT_LOW);
	assign wr_high  = wr & (wb_adr_i == gated_timer_pkg::OFS_COUNT_HIGH);
	assign wr_count = wr_low | wr_high;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
		end
	end

	// Unmapped offsets still ack and read zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req & ~wb_ack_o) begin
			unique case (wb_adr_i)
				gated_timer_pkg::OFS_COUNT_LOW:  wb_dat_o <= {24'h00_0000, count[7:0]};
				gated_timer_pkg::OFS_COUNT_HIGH: wb_dat_o <= {24'h00_0000, count[15:8]};
				gated_timer_pkg::OFS_CONTROL:    wb_dat_o <= {24'h00_0000, control};
				gated_timer_pkg::OFS_GATE:       wb_dat_o <= {24'h00_0000, gate_ctrl};
				gated_timer_pkg::OFS_IRQ_STATUS: wb_dat_o <= {31'h0000_0000, status_ovf};
				gated_timer_pkg::OFS_IRQ_MASK:   wb_dat_o <= {31'h0000_0000, mask_ovf};
				default:                         wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			control <= gated_timer_pkg::CONTROL_RST;
		end else if (wr && wb_adr_i == gated_timer_pkg::OFS_CONTROL) begin
			control <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gate_ctrl <= gated_timer_pkg::GATE_RST;
		end else if (wr && wb_adr_i == gated_timer_pkg::OFS_GATE) begin
			gate_ctrl <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mask_ovf <= 1'b0;
		end else if (wr && wb_adr_i == gated_timer_pkg::OFS_IRQ_MASK) begin
			mask_ovf <= wb_dat_i[gated_timer_pkg::OVF_BIT];
		end
	end

	// ==========================================================
	// Crystal oscillator amplifier
	// Kept alive in sleep, only the enable bit stops it
	assign crystal_out_oe  = crystal_osc_enable;
	assign crystal_out_pin = crystal_osc_enable & ~crystal_in_pin;

	// ==========================================================
	// Source edges
	logic ext_src;
	logic ext_rise;
	logic ext_fall;
	logic lf_rise;
	logic instr_tick;
	logic async_ext;
	logic awake;
	logic src_tick;

	assign ext_src   = crystal_osc_enable ? crystal_in_pin : ext_count_input;
	assign ext_rise  = ext_src & ~ext_prev;
	assign ext_fall  = ~ext_src & ext_prev;
	assign lf_rise   = low_freq_internal_osc & ~lf_prev;
	assign instr_tick = (instr_div == gated_timer_pkg::INSTR_LAST);
	assign async_ext = sync_disable_bit & (clock_select_field == gated_timer_pkg::CS_EXT);
	// Only the unsynchronised pin path keeps counting asleep
	assign awake     = ~sleep_mode | async_ext;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ext_prev <= 1'b0;
			lf_prev  <= 1'b0;
		end else begin
			ext_prev <= ext_src;
			lf_prev  <= low_freq_internal_osc;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			instr_div <= 2'h0;
		end else if (~sleep_mode) begin
			instr_div <= instr_div + 2'h1;
		end
	end

	always_comb begin
		unique case (clock_select_field)
			gated_timer_pkg::CS_INSTR: src_tick = instr_tick;
			gated_timer_pkg::CS_SYS:   src_tick = 1'b1;
			gated_timer_pkg::CS_EXT:   src_tick = ext_rise & armed;
			gated_timer_pkg::CS_LFOSC: src_tick = lf_rise;
		endcase
	end

	// ==========================================================
	// Falling edge arming
	// Cleared by reset, disable and count write; a sync/async switch
	// may still drop or add one count, left as is
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			armed <= 1'b0;
		end else if (~run_bit | wr_count) begin
			armed <= 1'b0;
		end else if (ext_fall) begin
			armed <= 1'b1;
		end
	end

	// ==========================================================
	// Prescaler and count
	logic presc_tick;
	logic enabled;
	logic inc;
	logic wrap;

	assign presc_tick = src_tick & awake & (presc == presc_last(prescale_field));
	assign enabled    = run_bit & (~gate_enable_bit | count_permit);
	assign inc        = presc_tick & enabled;
	assign wrap       = inc & (count == gated_timer_pkg::COUNT_MAX);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			presc <= 3'h0;
		end else if (wr_count | ~run_bit) begin
			presc <= 3'h0;
		end else if (src_tick & awake) begin
			presc <= presc_tick ? 3'h0 : presc + 3'h1;
		end
	end

	// Write wins over a coincident increment
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count <= gated_timer_pkg::COUNT_RST;
		end else if (wr_low) begin
			count[7:0] <= wb_dat_i[7:0];
		end else if (wr_high) begin
			count[15:8] <= wb_dat_i[7:0];
		end else if (inc) begin
			count <= count + 16'h0001;
		end
	end

	// ==========================================================
	// Overflow interrupt
	logic clr_ovf;

	assign clr_ovf = wr & (wb_adr_i == gated_timer_pkg::OFS_IRQ_STATUS)
		& wb_dat_i[gated_timer_pkg::OVF_BIT];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			status_ovf <= 1'b0;
		end else if (wrap) begin
			status_ovf <= 1'b1;
		end else if (clr_ovf) begin
			status_ovf <= 1'b0;
		end
	end

	assign irq = status_ovf & mask_ovf;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	write_replace_a: assert property (wr_low |=> count[7:0] == $past(wb_dat_i[7:0]))
		else $error("low byte write not applied");

	run_off_a: assert property (!run_bit && !wr_count |=> $stable(count))
		else $error("count moved while off");

	gate_hold_a: assert property (run_bit && gate_enable_bit
		&& !count_permit && !wr_count |=> $stable(count))
		else $error("count moved with gate closed");

	sysclk_rate_a: assert property ((clock_select_field == gated_timer_pkg::CS_SYS)
		&& run_bit && !gate_enable_bit && prescale_field == 2'h0 && !sleep_mode && !wr_count
		|=> count == $past(count) + 16'h0001)
		else $error("system clock not one count per cycle");

	presc_clear_a: assert property (wr_count |=> presc == 3'h0)
		else $error("prescaler not cleared by count write");

	disarm_a: assert property (wr_count || !run_bit |=> !armed)
		else $error("arming survived write or disable");

	unarmed_hold_a: assert property (clock_select_field == gated_timer_pkg::CS_EXT
		&& !armed && !wr_count |=> $stable(count))
		else $error("count before falling edge seen");

	ovf_flag_a: assert property (wrap |=> status_ovf ##0 count == gated_timer_pkg::COUNT_RST)
		else $error("rollover did not set flag");

	// Stop and count writes clear the prescaler legally, so they are left out
	sleep_hold_a: assert property (sleep_mode && !async_ext && run_bit && !wr_count
		|=> $stable(presc))
		else $error("sync path ran during sleep");

	osc_drive_a: assert property (crystal_osc_enable |-> crystal_out_oe
		&& crystal_out_pin == !crystal_in_pin)
		else $error("crystal amplifier not driven");

	irq_follow_a: assert property (wrap && mask_ovf
		&& !(wr && wb_adr_i == gated_timer_pkg::OFS_IRQ_MASK) |=> irq)
		else $error("overflow did not raise irq");

	ovf_async_c: cover property (sleep_mode && async_ext && wrap);
	ext_count_c: cover property (armed && inc);
	gated_c: cover property (gate_enable_bit && run_bit && !count_permit ##1 count_permit);
	presc8_c: cover property (prescale_field == 2'h3 && inc);

endmodule

// File: ext_clock_source.sv
// External count source: pin, crystal or slow oscillator seen by the timer.
// Assumes the bench calls emit() from its own sequence, one burst at a time.
`timescale 1ns/1ps

module ext_clock_source (
	// Clock
	input  wire logic clk,
	// Source output
	output logic      pin
);
	// ==========================================================
	// Burst generator
	// Idle low between bursts; a source that stands still
	initial pin = 1'b0;

	task automatic emit(input int n);
		repeat (n) begin
			repeat (3) @(posedge clk);
			pin <= 1'b1;
			repeat (3) @(posedge clk);
			pin <= 1'b0;
		end
		repeat (4) @(posedge clk);
	endtask
endmodule

// File: gated_sixteen_bit_timer_core_tb.sv
// Self-checking bench for the gated 16-bit timer core.
// Assumes the register map of gated_timer_pkg and a one-cycle bus answer.
`timescale 1ns/1ps

module gated_sixteen_bit_timer_core_tb;
	// ==========================================================
	// Stimulus and observation
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        pin;
	logic        permit = 1'b0;
	logic        sleep = 1'b0;
	logic        xout;
	logic        xoe;
	logic        irq;
	logic [7:0]  q;
	logic [7:0]  ctls [3] = '{8'h85, 8'h8d, 8'hc5};
	int          miscompares = 0;
	int          comparisons = 0;
	int          cycles = 0;

	always #2 clk = ~clk;

	gated_sixteen_bit_timer_core u_gated_sixteen_bit_timer_core (
		.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .ext_count_input(pin), .low_freq_internal_osc(pin),
		.crystal_in_pin(pin), .crystal_out_pin(xout), .crystal_out_oe(xoe),
		.count_permit(permit), .sleep_mode(sleep), .irq(irq));

	ext_clock_source u_ext_clock_source (.clk(clk), .pin(pin));

	// ==========================================================
	// Shared tasks
	task check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// No fixed latency assumed; the timeout ends a hung wait
	task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h1;
		wdat <= {24'h0, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] exp);
		xfer(a, 1'b0, 8'h00);
		check({8'h00, q}, {8'h00, exp});
	endtask

	task load(input logic [7:0] ctl, input logic [7:0] gate, input logic [15:0] s);
		xfer(gated_timer_pkg::OFS_CONTROL, 1'b1, ctl);
		xfer(gated_timer_pkg::OFS_GATE, 1'b1, gate);
		xfer(gated_timer_pkg::OFS_COUNT_LOW, 1'b1, s[7:0]);
		xfer(gated_timer_pkg::OFS_COUNT_HIGH, 1'b1, s[15:8]);
		xfer(gated_timer_pkg::OFS_CONTROL, 1'b1, ctl | 8'h01);
	endtask

	// Permit high for a known window; the tick count inside it is exact
	task gated(input logic [7:0] ctl, input logic [15:0] s, input int win, input logic [15:0] e);
		load(ctl, 8'h80, s);
		@(posedge clk);
		permit <= 1'b1;
		repeat (win) @(posedge clk);
		permit <= 1'b0;
		xfer(gated_timer_pkg::OFS_CONTROL, 1'b1, ctl);
		rd(gated_timer_pkg::OFS_COUNT_LOW, e[7:0]);
		rd(gated_timer_pkg::OFS_COUNT_HIGH, e[15:8]);
	endtask

	// ==========================================================
	// Scenarios
	task t_regs;
		for (int i = 0; i < 7; i++) rd(8'(i * 4), 8'h00);
		xfer(8'h18, 1'b1, 8'hff);
		rd(8'h18, 8'h00);
		xfer(gated_timer_pkg::OFS_CONTROL, 1'b1, 8'hf4);
		rd(gated_timer_pkg::OFS_CONTROL, 8'hf4);
		xfer(gated_timer_pkg::OFS_COUNT_LOW, 1'b1, 8'ha5);
		xfer(gated_timer_pkg::OFS_COUNT_HIGH, 1'b1, 8'h5a);
		rd(gated_timer_pkg::OFS_COUNT_LOW, 8'ha5);
		rd(gated_timer_pkg::OFS_COUNT_HIGH, 8'h5a);
		$display("test regs done");
	endtask

	task t_prescale;
		for (int p = 0; p < 4; p++) gated({2'h1, 2'(p), 4'h0}, 16'h0100, 3 << p, 16'h0103);
		gated(8'h00, 16'h00ff, 12, 16'h0102);
		gated(8'h10, 16'h0200, 24, 16'h0203);
		// Free run, no gate: three system ticks while the stop write is in flight
		load(8'h40, 8'h00, 16'h1000);
		xfer(gated_timer_pkg::OFS_CONTROL, 1'b1, 8'h40);
		rd(gated_timer_pkg::OFS_COUNT_LOW, 8'h03);
		sleep <= 1'b1;
		gated(8'h40, 16'h0000, 5, 16'h0000);
		sleep <= 1'b0;
		$display("test prescale done");
	endtask

	task t_overflow;
		gated(8'h40, 16'hfffe, 3, 16'h0001);
		rd(gated_timer_pkg::OFS_IRQ_STATUS, 8'h01);
		check({15'h0, irq}, 16'h0000);
		xfer(gated_timer_pkg::OFS_IRQ_MASK, 1'b1, 8'h01);
		@(posedge clk);
		check({15'h0, irq}, 16'h0001);
		xfer(gated_timer_pkg::OFS_IRQ_STATUS, 1'b1, 8'h01);
		@(posedge clk);
		check({15'h0, irq}, 16'h0000);
		rd(gated_timer_pkg::OFS_IRQ_STATUS, 8'h00);
		// Start-up wait: flag after 1025 crystal cycles, first edge unarmed
		load(8'h88, 8'h00, 16'hfc00);
		u_ext_clock_source.emit(1024);
		rd(gated_timer_pkg::OFS_IRQ_STATUS, 8'h00);
		u_ext_clock_source.emit(1);
		rd(gated_timer_pkg::OFS_IRQ_STATUS, 8'h01);
		check({15'h0, irq}, 16'h0001);
		xfer(gated_timer_pkg::OFS_IRQ_STATUS, 1'b1, 8'h01);
		// Wake on overflow from the unsynchronised pin while asleep
		load(8'h84, 8'h00, 16'hfffd);
		sleep <= 1'b1;
		u_ext_clock_source.emit(5);
		check({15'h0, irq}, 16'h0001);
		sleep <= 1'b0;
		xfer(gated_timer_pkg::OFS_CONTROL, 1'b1, 8'h84);
		rd(gated_timer_pkg::OFS_COUNT_LOW, 8'h01);
		$display("test overflow done");
	endtask

	// First rising edge after a count write is not counted on the pin
	task t_external;
		for (int i = 0; i < 3; i++) begin
			load(ctls[i] & 8'hfe, 8'h00, 16'h0000);
			sleep <= ~ctls[i][6];
			u_ext_clock_source.emit(5);
			check({14'h0, xoe, xout}, ctls[i][3] ? 16'h0003 : 16'h0000);
			xfer(gated_timer_pkg::OFS_CONTROL, 1'b1, ctls[i] & 8'hfe);
			sleep <= 1'b0;
			rd(gated_timer_pkg::OFS_COUNT_LOW, ctls[i][6] ? 8'h05 : 8'h04);
		end
		$display("test external done");
	endtask

	// ==========================================================
	// Sequence and verdict
	task complete_run;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run;
		end
	end

	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		t_regs;
		t_prescale;
		t_overflow;
		t_external;
		complete_run;
	end
endmodule
